// file: flash_protect.sv
// Protection and key lock controller for the second flash block
`include "prot_regs.svh"
`timescale 1ns/1ps
module flash_protect #(
   parameter int KEY_WRITE_CYCLES = `KEY_WRITE_CYCLES
) (
   input wire logic clk_i, // System clock, 100 MHz
   input wire logic reset_n_i, // Async reset, active low
   input wire logic ce_i, // Clock enable, freezes state when low
   input wire logic [31:0] bus_addr_i, // Register byte address
   input wire logic bus_wr_i, // Write strobe
   input wire logic bus_rd_i, // Read strobe
   input wire logic [31:0] bus_wdata_i, // Write data
   output logic [31:0] bus_rdata_o, // Read data, one cycle after strobe
   output logic dbg_read_allow_o, // Debug port may read the block
   output logic array_write_o, // Halfword program pulse
   output logic array_page_erase_o, // Page erase pulse
   output logic array_mass_erase_o, // Mass erase pulse
   output logic [15:0] array_addr_o, // Array byte address
   output logic [15:0] array_data_o // Array program data
);
   logic [1:0] rst_sync_q;
   logic rst_n;

   // Reset release is kept free of the clock enable so it cannot hang
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_q[1];

   nv_if #(.W(32)) nv ();

   nv_store #(.W(32), .ERASED(`KEY_ERASED)) u_store (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .port(nv)
   );

   logic [31:0] work_q, work_d;
   logic [31:0] lock_q, lock_d;
   logic [31:0] key_q, key_d;
   logic [15:0] mode_q, mode_d;
   logic [15:0] addr_q, addr_d;
   logic [15:0] data_q, data_d;
   logic pass_q, pass_d;
   logic fail_q, fail_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic pe_q, pe_d;
   logic me_q, me_d;
   prot_pkg::state_t state_q, state_d;

   logic page_writable;
   logic dbg_ok;

   page_guard u_guard (
      .work_i(work_q),
      .page_i(addr_q[`PAGE_MSB:`PAGE_LSB]),
      .page_writable_o(page_writable),
      .dbg_read_ok_o(dbg_ok)
   );

   // Supplied key is whatever sits in the address and data registers
   function automatic logic key_accepted(input logic [31:0] saved, input logic [31:0] given);
      if (saved == `KEY_ERASED) begin
         key_accepted = 1'b1;
      end else if (saved == `KEY_PERMANENT) begin
         key_accepted = 1'b0;
      end else begin
         key_accepted = (given == saved);
      end
   endfunction : key_accepted

   logic [31:0] supplied_key;
   logic busy;
   logic ew_en;
   logic lock_mode;
   logic is_wr;
   logic set_pass;
   logic set_fail;
   logic prot_write;
   logic [7:0] cmd;

   assign supplied_key = {addr_q, data_q};
   assign busy = (state_q != prot_pkg::ST_IDLE);
   assign ew_en = mode_q[`MODE_EW_ENABLE];
   assign lock_mode = (mode_q[`MODE_LOCK_HI:`MODE_LOCK_LO] == `MODE_LOCK_PATTERN);
   assign cmd = bus_wdata_i[7:0];

   always_comb begin
      work_d = work_q;
      lock_d = lock_q;
      key_d = key_q;
      mode_d = mode_q;
      addr_d = addr_q;
      data_d = data_q;
      cnt_d = cnt_q;
      state_d = state_q;
      wr_d = 1'b0;
      pe_d = 1'b0;
      me_d = 1'b0;
      set_pass = 1'b0;
      set_fail = 1'b0;
      prot_write = 1'b0;
      is_wr = bus_wr_i && !busy;
      nv.idx = `NV_KEY_IDX;
      nv.we = 1'b0;
      nv.erase = 1'b0;
      nv.wdata = supplied_key;

      case (state_q)
         // fetch key then pattern after reset
         prot_pkg::ST_BOOT_KEY: begin
            nv.idx = `NV_KEY_IDX;
            state_d = prot_pkg::ST_BOOT_PATTERN;
         end
         prot_pkg::ST_BOOT_PATTERN: begin
            nv.idx = `NV_PATTERN_IDX;
            key_d = nv.rdata;
            state_d = prot_pkg::ST_BOOT_APPLY;
         end
         prot_pkg::ST_BOOT_APPLY: begin
            nv.idx = `NV_PATTERN_IDX;
            if (key_q != `KEY_ERASED) begin
               work_d = nv.rdata;
            end
            state_d = prot_pkg::ST_IDLE;
         end
         prot_pkg::ST_KEY_PATTERN: begin
            nv.idx = `NV_PATTERN_IDX;
            nv.we = 1'b1;
            nv.wdata = lock_q;
            state_d = prot_pkg::ST_KEY_BUSY;
         end
         prot_pkg::ST_KEY_BUSY: begin
            // busy held for the key write
            if (cnt_q == 16'(KEY_WRITE_CYCLES - 1)) begin
               key_d = supplied_key;
               set_pass = 1'b1;
               state_d = prot_pkg::ST_IDLE;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         prot_pkg::ST_IDLE: begin
         end
         default: state_d = prot_pkg::ST_IDLE;
      endcase

      // Protection and command writes during a busy phase are refused
      if (bus_wr_i && busy && (bus_addr_i == `ADDR_WORK || bus_addr_i == `ADDR_LOCK
                               || bus_addr_i == `ADDR_COMMAND)) begin
         set_fail = 1'b1;
      end

      if (is_wr) begin
         case (bus_addr_i)
            `ADDR_MODE: mode_d = bus_wdata_i[15:0];
            `ADDR_ADDRESS: addr_d = bus_wdata_i[15:0];
            `ADDR_DATA: data_d = bus_wdata_i[15:0];
            `ADDR_WORK, `ADDR_LOCK: prot_write = 1'b1;
            `ADDR_COMMAND: begin
               case (cmd)
                  `CMD_KEY_WRITE: begin
                     if (ew_en && lock_mode && key_accepted(key_q, supplied_key)) begin
                        nv.idx = `NV_KEY_IDX;
                        nv.we = 1'b1;
                        nv.wdata = supplied_key;
                        cnt_d = 16'h0000;
                        state_d = prot_pkg::ST_KEY_PATTERN;
                     end else begin
                        set_fail = 1'b1;
                     end
                  end
                  `CMD_WRITE, `CMD_PAGE_ERASE: begin
                     if (ew_en && page_writable) begin
                        wr_d = (cmd == `CMD_WRITE);
                        pe_d = (cmd == `CMD_PAGE_ERASE);
                        set_pass = 1'b1;
                     end else begin
                        set_fail = 1'b1;
                     end
                  end
                  `CMD_MASS_ERASE: begin
                     if (ew_en) begin
                        nv.erase = 1'b1;
                        key_d = `KEY_ERASED;
                        work_d = `RST_WORK;
                        me_d = 1'b1;
                        set_pass = 1'b1;
                     end else begin
                        set_fail = 1'b1;
                     end
                  end
                  default: set_fail = 1'b1;
               endcase
            end
            default: ;
         endcase
      end

      // protection registers need the saved key
      if (prot_write) begin
         if (key_accepted(key_q, supplied_key)) begin
            if (bus_addr_i == `ADDR_WORK) begin
               work_d = bus_wdata_i;
            end else begin
               lock_d = bus_wdata_i;
            end
         end else begin
            set_fail = 1'b1;
         end
      end

      // status read clears, a new event wins
      pass_d = set_pass || (pass_q && !(bus_rd_i && bus_addr_i == `ADDR_STATUS));
      fail_d = set_fail || (fail_q && !(bus_rd_i && bus_addr_i == `ADDR_STATUS));

      rdata_d = rdata_q;
      if (bus_rd_i) begin
         case (bus_addr_i)
            `ADDR_STATUS: rdata_d = {29'h0, busy, fail_q, pass_q};
            `ADDR_MODE: rdata_d = {16'h0, mode_q};
            `ADDR_ADDRESS: rdata_d = {16'h0, addr_q};
            `ADDR_DATA: rdata_d = {16'h0, data_q};
            `ADDR_LOCK: rdata_d = lock_q;
            `ADDR_WORK: rdata_d = work_q;
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         work_q <= `RST_WORK;
         lock_q <= `RST_LOCK;
         key_q <= `KEY_ERASED;
         mode_q <= `RST_MODE;
         addr_q <= `RST_ADDRESS;
         data_q <= `RST_DATA;
         pass_q <= 1'b0;
         fail_q <= 1'b0;
         rdata_q <= 32'h00000000;
         cnt_q <= 16'h0000;
         wr_q <= 1'b0;
         pe_q <= 1'b0;
         me_q <= 1'b0;
         state_q <= prot_pkg::ST_BOOT_KEY;
      end else if (ce_i) begin
         work_q <= work_d;
         lock_q <= lock_d;
         key_q <= key_d;
         mode_q <= mode_d;
         addr_q <= addr_d;
         data_q <= data_d;
         pass_q <= pass_d;
         fail_q <= fail_d;
         rdata_q <= rdata_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         pe_q <= pe_d;
         me_q <= me_d;
         state_q <= state_d;
      end
   end

   assign bus_rdata_o = rdata_q;
   assign dbg_read_allow_o = dbg_ok;
   assign array_write_o = wr_q;
   assign array_page_erase_o = pe_q;
   assign array_mass_erase_o = me_q;
   assign array_addr_o = addr_q;
   assign array_data_o = data_q;
endmodule : flash_protect

// file: flash_protect_bench.sv
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
`include "prot_regs.svh"
module flash_protect_bench;
   typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
   logic clk_i, reset_n_i, ce_i, bus_wr_i, bus_rd_i, rd_seen;
   logic [31:0] bus_addr_i, bus_wdata_i, bus_rdata_o, rnd, pat;
   logic dbg_read_allow_o, array_write_o, array_page_erase_o, array_mass_erase_o;
   logic [15:0] array_addr_o, array_data_o;
   logic [6:0] pg;
   logic wp;
   note_t notes[$];
   int n_fail;
   int checks_done;

   flash_protect #(.KEY_WRITE_CYCLES(2)) u_flash_protect (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
      .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
      .dbg_read_allow_o(dbg_read_allow_o), .array_write_o(array_write_o),
      .array_page_erase_o(array_page_erase_o), .array_mass_erase_o(array_mass_erase_o),
      .array_addr_o(array_addr_o), .array_data_o(array_data_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // Read data lands one cycle after the strobe; mask zero marks a poll
   always @(posedge clk_i) rd_seen <= bus_rd_i & ce_i;
   always @(negedge clk_i) begin
      if (rd_seen === 1'b1 && notes.size() > 0) begin
         if (notes[0].m != 32'h0) check("read data", notes[0].e & notes[0].m, bus_rdata_o & notes[0].m);
         void'(notes.pop_front());
      end
   end

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_addr_i <= a;
      bus_wdata_i <= d;
      bus_wr_i <= 1'b1;
      @(posedge clk_i);
      bus_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{e, m});
      @(posedge clk_i);
      bus_addr_i <= a;
      bus_rd_i <= 1'b1;
      @(posedge clk_i);
      bus_rd_i <= 1'b0;
      @(negedge clk_i);
   endtask : rd

   task automatic poll(input logic [2:0] e);
      for (int i = 0; i < 40; i++) begin
         rd(`ADDR_STATUS, 32'h0, 32'h0);
         if (bus_rdata_o[`STA_BUSY] === 1'b0) break;
      end
      check("status", {29'h0, e}, bus_rdata_o & 32'h7);
   endtask : poll

   task automatic do_reset();
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      poll(3'h0);
   endtask : do_reset

   // Key goes into address and data first, so the lock write is itself keyed
   task automatic key_seq(input logic [31:0] p, input logic [15:0] hi, input logic [15:0] lo,
         input logic [2:0] e);
      wr(`ADDR_ADDRESS, {16'h0, hi});
      wr(`ADDR_DATA, {16'h0, lo});
      wr(`ADDR_LOCK, p);
      wr(`ADDR_MODE, 32'h48);
      wr(`ADDR_COMMAND, {24'h0, `CMD_KEY_WRITE});
      // A refused command shows fail at once; this read clears it, so the poll sees idle
      rd(`ADDR_STATUS, {29'h0, e[0], e[1], 1'h0}, 32'h6);
      poll({2'h0, e[0]});
   endtask : key_seq

   task automatic mass();
      wr(`ADDR_COMMAND, {24'h0, `CMD_MASS_ERASE});
      @(negedge clk_i);
      check("mass erase pulse", 32'h1, 32'(array_mass_erase_o));
      rd(`ADDR_WORK, `KEY_ERASED, '1);
   endtask : mass

   initial begin
      reset_n_i = 1'b0;
      ce_i = 1'b1;
      bus_addr_i = 32'h0;
      bus_wdata_i = 32'h0;
      bus_wr_i = 1'b0;
      bus_rd_i = 1'b0;
      n_fail = 0;
      checks_done = 0;
      rnd = 32'h99193590;
      do_reset();
      rd(`ADDR_WORK, `RST_WORK, '1);
      rd(`ADDR_LOCK, `RST_LOCK, '1);
      rd(32'hFFFF0E98, 32'h0, '1);
      wr(`ADDR_MODE, 32'h8);
      for (int k = 0; k < 12; k++) begin
         rnd = xorshift(rnd);
         pat = rnd;
         pg = (k == 0) ? 7'h00 : (k == 1) ? 7'h77 : (k == 2) ? 7'h78 : (k == 3) ? 7'h7F : rnd[22:16];
         wr(`ADDR_WORK, pat);
         @(negedge clk_i);
         check("debug read", 32'(pat[31]), 32'(dbg_read_allow_o));
         wr(`ADDR_ADDRESS, {16'h0, pg, 9'h0});
         wr(`ADDR_DATA, {16'h0, rnd[31:16]});
         wr(`ADDR_COMMAND, rnd[8] ? 32'h2 : 32'h5);
         @(negedge clk_i);
         wp = (pg < 7'h78) ? pat[pg >> 2] : pat[30];
         check("write pulse", 32'(rnd[8] & wp), 32'(array_write_o));
         check("erase", 32'(!rnd[8] & wp), 32'(array_page_erase_o));
         check("array address", 32'({pg, 9'h0}), 32'(array_addr_o));
         check("array data", 32'(rnd[31:16]), 32'(array_data_o));
         rd(`ADDR_STATUS, {30'h0, !wp, wp}, 32'h3);
         rd(`ADDR_STATUS, 32'h0, 32'h3);
      end
      key_seq(32'hFFFFFFFB, 16'h66BB, 16'hAA55, 3'h1);
      wr(`ADDR_ADDRESS, 32'h1234);
      wr(`ADDR_WORK, 32'h0);
      rd(`ADDR_STATUS, 32'h2, 32'h3);
      rd(`ADDR_WORK, pat, '1);
      key_seq(32'hFFFFFFF0, 16'h1234, 16'hAA55, 3'h2);
      wr(`ADDR_ADDRESS, 32'h66BB);
      wr(`ADDR_WORK, 32'hFFFF);
      rd(`ADDR_WORK, 32'hFFFF, '1);
      do_reset();
      rd(`ADDR_WORK, 32'hFFFFFFFB, '1);
      key_seq(32'hFFFFFFFE, 16'h66BB, 16'hAA55, 3'h1);
      do_reset();
      rd(`ADDR_WORK, 32'hFFFFFFFE, '1);
      wr(`ADDR_MODE, 32'h8);
      mass();
      key_seq(32'h0, 16'hDEAD, 16'hDEAD, 3'h1);
      wr(`ADDR_WORK, 32'h0);
      rd(`ADDR_STATUS, 32'h2, 32'h3);
      key_seq(32'hFFFFFFFF, 16'hDEAD, 16'hDEAD, 3'h2);
      mass();
      wr(`ADDR_WORK, 32'h0);
      rd(`ADDR_WORK, 32'h0, '1);
      // Key command without the lock pattern in the mode register is refused
      wr(`ADDR_MODE, 32'h8);
      wr(`ADDR_COMMAND, {24'h0, `CMD_KEY_WRITE});
      rd(`ADDR_STATUS, 32'h2, 32'h2);
      wr(`ADDR_COMMAND, 32'hF);
      rd(`ADDR_STATUS, 32'h2, 32'h3);
      // A write strobed while the clock enable is low must leave no trace
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(`ADDR_WORK, 32'hFFFFFFFF);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rd(`ADDR_WORK, 32'h0, '1);
      finish_test();
   end

   initial begin
      #100us;
      n_fail++;
      finish_test();
   end
endmodule : flash_protect_bench

// file: flash_protect_monitor.sv
// Concurrent checks on the ports of the flash protection block
`timescale 1ns/1ps
`include "prot_regs.svh"
module flash_protect_monitor #(
   parameter int KEY_WRITE_CYCLES = 16
) (
   input wire logic clk_i, // System clock
   input wire logic reset_n_i, // Async reset
   input wire logic ce_i, // Clock enable
   input wire logic [31:0] bus_addr_i, // Address
   input wire logic bus_wr_i, // Write strobe
   input wire logic bus_rd_i, // Read strobe
   input wire logic [31:0] bus_wdata_i, // Write data
   input wire logic [31:0] bus_rdata_o, // Read data
   input wire logic dbg_read_allow_o, // Debug read allowed
   input wire logic array_write_o, // Program pulse
   input wire logic array_page_erase_o, // Page erase pulse
   input wire logic array_mass_erase_o, // Mass erase pulse
   input wire logic [15:0] array_addr_o, // Array address
   input wire logic [15:0] array_data_o // Array data
);
   logic [3:0] up_q;
   logic [3:0] up_d;
   logic cmd_wr;
   // Boot reload may move the debug permission, so wait until it is long over
   always_comb begin
      up_d = (up_q == 4'hF) ? up_q : up_q + 4'h1;
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         up_q <= 4'h0;
      end else begin
         up_q <= up_d;
      end
   end
   assign cmd_wr = bus_wr_i && ce_i && bus_addr_i == `ADDR_COMMAND;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_debug_follows_write: assert property ($changed(dbg_read_allow_o) && up_q == 4'hF
      |-> $past(bus_wr_i && ce_i && (bus_addr_i == `ADDR_WORK || bus_addr_i == `ADDR_COMMAND)))
      else $error("debug permission moved without a register write");
   a_mass_opens_debug: assert property (array_mass_erase_o |-> ##[0:1] dbg_read_allow_o)
      else $error("debug read still blocked after mass erase");
   a_write_needs_cmd: assert property (array_write_o
      |-> $past(cmd_wr && bus_wdata_i[7:0] == `CMD_WRITE))
      else $error("program pulse without program command");
   a_erase_needs_cmd: assert property (array_page_erase_o
      |-> $past(cmd_wr && bus_wdata_i[7:0] == `CMD_PAGE_ERASE))
      else $error("page erase pulse without erase command");
   a_mass_needs_cmd: assert property (array_mass_erase_o
      |-> $past(cmd_wr && bus_wdata_i[7:0] == `CMD_MASS_ERASE))
      else $error("mass erase pulse without mass erase command");
   a_pulses_exclusive: assert property ($onehot0({array_write_o, array_page_erase_o,
      array_mass_erase_o}))
      else $error("two array pulses together");
   a_unmapped_reads_zero: assert property (bus_rd_i && ce_i && !(bus_addr_i inside {`ADDR_STATUS,
      `ADDR_MODE, `ADDR_COMMAND, `ADDR_DATA, `ADDR_ADDRESS, `ADDR_LOCK, `ADDR_WORK})
      |=> bus_rdata_o == 32'h0)
      else $error("unmapped read returned data");
   a_rdata_holds: assert property ($changed(bus_rdata_o) |-> $past(bus_rd_i && ce_i))
      else $error("read data changed without a read");
endmodule : flash_protect_monitor

bind flash_protect flash_protect_monitor #(.KEY_WRITE_CYCLES(KEY_WRITE_CYCLES)) u_monitor (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
   .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
   .bus_rdata_o(bus_rdata_o), .dbg_read_allow_o(dbg_read_allow_o),
   .array_write_o(array_write_o), .array_page_erase_o(array_page_erase_o),
   .array_mass_erase_o(array_mass_erase_o), .array_addr_o(array_addr_o),
   .array_data_o(array_data_o));

// file: nv_if.sv
// Port bundle between the protection controller and its non-volatile store
`timescale 1ns/1ps
interface nv_if #(
   parameter int W = 32
);
   logic idx;
   logic we;
   logic erase;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;

   modport ctrl (output idx, output we, output erase, output wdata, input rdata);
   modport mem (input idx, input we, input erase, input wdata, output rdata);
endinterface : nv_if

// file: nv_store.sv
// Two-word non-volatile store for the saved key and the committed protection pattern
`timescale 1ns/1ps
module nv_store #(
   parameter int W = 32,
   parameter logic [W-1:0] ERASED = '1
) (
   input wire logic clk_i, // System clock
   input wire logic ce_i, // Clock enable
   nv_if.mem port // Store port
);
   // No reset: contents must survive every reset; simulation starts erased
   logic [W-1:0] mem_q [2] = '{default: ERASED};
   logic [W-1:0] mem_d [2];
   logic [W-1:0] rdata_q = '0;
   logic [W-1:0] rdata_d;

   always_comb begin
      mem_d = mem_q;
      if (port.erase) begin
         mem_d[0] = ERASED;
         mem_d[1] = ERASED;
      end else if (port.we) begin
         mem_d[port.idx] = port.wdata;
      end
      rdata_d = mem_q[port.idx];
   end

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         mem_q <= mem_d;
         rdata_q <= rdata_d;
      end
   end

   assign port.rdata = rdata_q;
endmodule : nv_store

// file: page_guard.sv
// Maps a page to its protection bit and exposes the debug read permission
`include "prot_regs.svh"
`timescale 1ns/1ps
module page_guard (
   input wire logic [31:0] work_i, // Working protection pattern
   input wire logic [6:0] page_i, // Target page
   output logic page_writable_o, // Page may be written or erased
   output logic dbg_read_ok_o // Debug port may read the block
);
   function automatic logic [4:0] group_of(input logic [6:0] page);
      logic [6:0] g;
      g = page >> `GROUP_SHIFT;
      if (page >= `HIGH_GROUP_FIRST_PAGE) begin
         group_of = 5'(`HIGH_GROUP_BIT);
      end else begin
         group_of = g[4:0];
      end
   endfunction : group_of

   assign page_writable_o = work_i[group_of(page_i)];
   assign dbg_read_ok_o = work_i[`DBG_READ_BIT];
endmodule : page_guard

// file: prot_pkg.sv
// Types shared by the flash protection block
package prot_pkg;

   typedef enum logic [2:0] {
      ST_BOOT_KEY,
      ST_BOOT_PATTERN,
      ST_BOOT_APPLY,
      ST_IDLE,
      ST_KEY_PATTERN,
      ST_KEY_BUSY
   } state_t;

endpackage : prot_pkg

// file: prot_regs.svh
// Register map, field positions, reset values and counts of the flash protection block
`ifndef PROT_REGS_SVH
`define PROT_REGS_SVH

`define ADDR_STATUS 32'hFFFF0E80
`define ADDR_MODE 32'hFFFF0E84
`define ADDR_COMMAND 32'hFFFF0E88
`define ADDR_DATA 32'hFFFF0E8C
`define ADDR_ADDRESS 32'hFFFF0E90
`define ADDR_LOCK 32'hFFFF0E9C
`define ADDR_WORK 32'hFFFF0EA0

`define RST_WORK 32'hFFFFFFFF
`define RST_LOCK 32'h00000000
`define RST_MODE 16'h0000
`define RST_DATA 16'h0000
`define RST_ADDRESS 16'h0000

`define KEY_ERASED 32'hFFFFFFFF
`define KEY_PERMANENT 32'hDEADDEAD

`define CMD_WRITE 8'h02
`define CMD_PAGE_ERASE 8'h05
`define CMD_MASS_ERASE 8'h06
`define CMD_KEY_WRITE 8'h0C

`define MODE_LOCK_HI 6
`define MODE_LOCK_LO 5
`define MODE_LOCK_PATTERN 2'h2
`define MODE_EW_ENABLE 3

`define STA_PASS 0
`define STA_FAIL 1
`define STA_BUSY 2

`define DBG_READ_BIT 31
`define HIGH_GROUP_BIT 30
`define HIGH_GROUP_FIRST_PAGE 7'h78
`define GROUP_SHIFT 2
`define PAGE_LSB 9
`define PAGE_MSB 15

`define NV_KEY_IDX 1'h0
`define NV_PATTERN_IDX 1'h1
`define KEY_WRITE_CYCLES 16

`endif
